// ==== core/sps_pkg.sv ====
// Package with timing constants and states for the sensor power sequencer
package sps_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int RAIL_STEP_US = 100;
    localparam int HARD_RESET_US = 1000;
    localparam int PLL_LOCK_US = 1000;
    localparam int OFF_WAIT_MS = 100;
    localparam int INIT_REF_CLOCKS = 150000;
    localparam int RAIL_STEP_CYC = RAIL_STEP_US * (CLK_HZ / 1_000_000);
    localparam int HARD_RESET_CYC = HARD_RESET_US * (CLK_HZ / 1_000_000);
    localparam int PLL_LOCK_CYC = PLL_LOCK_US * (CLK_HZ / 1_000_000);
    localparam int OFF_WAIT_CYC = OFF_WAIT_MS * (CLK_HZ / 1_000);
    localparam int NUM_RAILS = 5;
    localparam logic [15:0] CTRL_ADDR = 16'h301a;
    localparam int STREAM_BIT = 2;
    localparam int REF_DIV = 2;
    typedef enum logic [1:0] {
        SPS_OFF,
        SPS_INIT,
        SPS_STANDBY,
        SPS_STREAM
    } sps_sensor_e;
endpackage

// ==== core/sps_link_if.sv ====
// Interface joining the host sequencer and the sensor end
`timescale 1ns/100ps
interface sps_link_if;
    logic [4:0] rail_en;
    logic external_ref_clock;
    logic reset_n;
    logic cfg_we;
    logic [15:0] cfg_addr;
    logic [15:0] cfg_wdata;
    logic standby;
    logic init_done;
    logic [11:0] pix_o;
    logic pix_oe_n;
    logic line_end;
    modport host (
        output rail_en, external_ref_clock, reset_n, cfg_we, cfg_addr,
        output cfg_wdata,
        input standby, init_done
    );
    modport sensor (
        input rail_en, external_ref_clock, reset_n, cfg_we, cfg_addr,
        input cfg_wdata,
        output standby, init_done, pix_o, pix_oe_n, line_end
    );
endinterface

// ==== core/sps_sync.sv ====
// Three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/100ps
module sps_sync #(
    parameter logic INIT = 1'b0
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic d,
    output logic q,
    output logic rise
);
    logic s1, s2, s3;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
            q <= INIT;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                q <= s3;
        end
    end
    assign rise = (s2 == s3) && s3 && !q;
endmodule

// ==== core/sps_sensor.sv ====
// Sensor end: reset, initialization, standby and streaming behaviour
`timescale 1ns/100ps
module sps_sensor #(
    parameter int INIT_CLOCKS = sps_pkg::INIT_REF_CLOCKS,
    parameter int LINE_LEN = 64
) (
    input wire logic ref_clk,
    input wire logic srst,
    sps_link_if.sensor link,
    output logic streaming
);
    initial begin
        if (INIT_CLOCKS < 1 || LINE_LEN < 2)
            $error("sps_sensor: bad parameter");
    end
    sps_pkg::sps_sensor_e state;
    logic rst_n_s, refc_rise;
    logic [31:0] init_cnt;
    logic [15:0] col;
    logic stream_req;
    sps_sync #(.INIT(1'b0)) u_rst (.ref_clk(ref_clk), .srst(srst),
        .d(link.reset_n), .q(rst_n_s), .rise());
    sps_sync #(.INIT(1'b0)) u_clk (.ref_clk(ref_clk), .srst(srst),
        .d(link.external_ref_clock), .q(), .rise(refc_rise));
    // Control write of the streaming bit, honoured only in standby and streaming
    always_ff @(posedge ref_clk) begin
        if (srst || !rst_n_s)
            stream_req <= 1'b0;
        else if (link.cfg_we && link.cfg_addr == sps_pkg::CTRL_ADDR &&
                 state != sps_pkg::SPS_INIT && state != sps_pkg::SPS_OFF)
            stream_req <= link.cfg_wdata[sps_pkg::STREAM_BIT];
    end
    always_ff @(posedge ref_clk) begin
        if (srst || !rst_n_s) begin
            state <= sps_pkg::SPS_OFF;
            init_cnt <= '0;
        end else begin
            unique case (state)
                sps_pkg::SPS_OFF: begin
                    state <= sps_pkg::SPS_INIT;
                    init_cnt <= '0;
                end
                sps_pkg::SPS_INIT: begin
                    if (refc_rise)
                        init_cnt <= init_cnt + 32'h1;
                    if (init_cnt == 32'(INIT_CLOCKS))
                        state <= sps_pkg::SPS_STANDBY;
                end
                sps_pkg::SPS_STANDBY:
                    if (stream_req)
                        state <= sps_pkg::SPS_STREAM;
                sps_pkg::SPS_STREAM:
                    // Finish the current row before standby
                    if (!stream_req && col == 16'(LINE_LEN - 1))
                        state <= sps_pkg::SPS_STANDBY;
            endcase
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst || state != sps_pkg::SPS_STREAM)
            col <= '0;
        else if (col == 16'(LINE_LEN - 1))
            col <= '0;
        else
            col <= col + 16'h1;
    end
    always_ff @(posedge ref_clk) begin
        if (srst || !rst_n_s)
            link.pix_o <= '0;
        else if (state == sps_pkg::SPS_STREAM)
            link.pix_o <= col[11:0];
    end
    // High impedance whenever reset is held or not streaming
    assign link.pix_oe_n = !(rst_n_s && state == sps_pkg::SPS_STREAM);
    assign link.line_end = (state == sps_pkg::SPS_STREAM) &&
        (col == 16'(LINE_LEN - 1));
    assign link.standby = (state == sps_pkg::SPS_STANDBY);
    assign link.init_done = (state == sps_pkg::SPS_STANDBY) ||
        (state == sps_pkg::SPS_STREAM);
    assign streaming = (state == sps_pkg::SPS_STREAM);
endmodule

// ==== core/sps_host.sv ====
// Host sequencer: rails, reference clock, reset, configuration, shutdown
`timescale 1ns/100ps
module sps_host #(
    parameter int STEP_CYC = sps_pkg::RAIL_STEP_CYC,
    parameter int RESET_CYC = sps_pkg::HARD_RESET_CYC,
    parameter int INIT_CLOCKS = sps_pkg::INIT_REF_CLOCKS,
    parameter int LOCK_CYC = sps_pkg::PLL_LOCK_CYC,
    parameter int OFF_CYC = sps_pkg::OFF_WAIT_CYC
) (
    input wire logic ref_clk,
    input wire logic srst,
    sps_link_if.host link,
    input wire logic power_on,
    output logic powered,
    output logic busy
);
    initial begin
        if (STEP_CYC < 1 || RESET_CYC < 1 || LOCK_CYC < 1 ||
            OFF_CYC < 1 || INIT_CLOCKS < 1)
            $error("sps_host: bad parameter");
    end
    typedef enum logic [3:0] {
        H_IDLE, H_RAIL_UP, H_CLK_ON, H_RESET, H_INIT, H_CONFIG,
        H_LOCK, H_STREAM_ON, H_ON, H_STREAM_OFF, H_WAIT_SB,
        H_RAIL_DN, H_OFF_WAIT
    } sps_host_e;
    sps_host_e state;
    logic [31:0] cnt;
    logic [2:0] rail_idx;
    logic [1:0] div;
    logic clk_run, ref_q;
    // Init wait in host ref_clk cycles covering INIT_CLOCKS periods of the divided clock
    localparam int INIT_CYC = INIT_CLOCKS * sps_pkg::REF_DIV * 2 + 8;
    function automatic logic cnt_done(input logic [31:0] c,
                                      input int lim);
        return c >= 32'(lim - 1);
    endfunction
    // Reference clock from a divider, gated until rails are stable
    always_ff @(posedge ref_clk) begin
        if (srst || !clk_run) begin
            div <= '0;
            ref_q <= 1'b0;
        end else if (div == 2'(sps_pkg::REF_DIV - 1)) begin
            div <= '0;
            ref_q <= !ref_q;
        end else
            div <= div + 2'h1;
    end
    assign link.external_ref_clock = ref_q;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= H_IDLE;
            cnt <= '0;
            rail_idx <= '0;
            link.rail_en <= '0;
            clk_run <= 1'b0;
            link.reset_n <= 1'b0;
            link.cfg_we <= 1'b0;
            link.cfg_addr <= '0;
            link.cfg_wdata <= '0;
        end else begin
            cnt <= cnt + 32'h1;
            link.cfg_we <= 1'b0;
            unique case (state)
                H_IDLE:
                    if (power_on) begin
                        // PLL rail first, alone
                        link.rail_en <= 5'h01;
                        rail_idx <= 3'h1;
                        cnt <= '0;
                        state <= H_RAIL_UP;
                    end
                H_RAIL_UP:
                    if (cnt_done(cnt, STEP_CYC)) begin
                        cnt <= '0;
                        if (rail_idx == 3'(sps_pkg::NUM_RAILS))
                            state <= H_CLK_ON;
                        else begin
                            link.rail_en[rail_idx] <= 1'b1;
                            rail_idx <= rail_idx + 3'h1;
                        end
                    end
                H_CLK_ON: begin
                    clk_run <= 1'b1;
                    cnt <= '0;
                    state <= H_RESET;
                end
                H_RESET:
                    if (cnt_done(cnt, RESET_CYC)) begin
                        link.reset_n <= 1'b1;
                        cnt <= '0;
                        state <= H_INIT;
                    end
                H_INIT:
                    if (cnt_done(cnt, INIT_CYC) && link.init_done)
                        state <= H_CONFIG;
                H_CONFIG: begin
                    // Settings write with streaming still clear
                    link.cfg_we <= 1'b1;
                    link.cfg_addr <= sps_pkg::CTRL_ADDR;
                    link.cfg_wdata <= '0;
                    cnt <= '0;
                    state <= H_LOCK;
                end
                H_LOCK:
                    if (cnt_done(cnt, LOCK_CYC))
                        state <= H_STREAM_ON;
                H_STREAM_ON: begin
                    link.cfg_we <= 1'b1;
                    link.cfg_addr <= sps_pkg::CTRL_ADDR;
                    link.cfg_wdata <= 16'h1 << sps_pkg::STREAM_BIT;
                    state <= H_ON;
                end
                H_ON:
                    if (!power_on)
                        state <= H_STREAM_OFF;
                H_STREAM_OFF: begin
                    link.cfg_we <= 1'b1;
                    link.cfg_addr <= sps_pkg::CTRL_ADDR;
                    link.cfg_wdata <= '0;
                    cnt <= '0;
                    state <= H_WAIT_SB;
                end
                H_WAIT_SB:
                    // Skip the first cycles while the write lands
                    if (cnt_done(cnt, 8) && link.standby) begin
                        link.reset_n <= 1'b0;
                        clk_run <= 1'b0;
                        rail_idx <= 3'(sps_pkg::NUM_RAILS - 1);
                        state <= H_RAIL_DN;
                    end
                H_RAIL_DN: begin
                    link.rail_en[rail_idx] <= 1'b0;
                    cnt <= '0;
                    if (rail_idx == 3'h0)
                        state <= H_OFF_WAIT;
                    else
                        rail_idx <= rail_idx - 3'h1;
                end
                H_OFF_WAIT:
                    if (cnt_done(cnt, OFF_CYC))
                        state <= H_IDLE;
            endcase
        end
    end
    assign powered = (state == H_ON);
    assign busy = (state != H_IDLE) && (state != H_ON);
endmodule

// ==== testbench/sps_assertions.sv ====
// Concurrent checks on the link between host and sensor ends
`timescale 1ns/100ps
module sps_assertions (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [4:0] rail_en,
    input wire logic external_ref_clock,
    input wire logic reset_n,
    input wire logic cfg_we,
    input wire logic [15:0] cfg_addr,
    input wire logic [15:0] cfg_wdata,
    input wire logic standby,
    input wire logic init_done,
    input wire logic pix_oe_n,
    input wire logic line_end
);
    logic [7:0] we_gap;
    logic [7:0] off_gap;
    logic [7:0] hold_cnt;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    always_ff @(posedge ref_clk) begin
        if (srst || cfg_we) we_gap <= 8'h00;
        else if (we_gap != 8'hff) we_gap <= we_gap + 8'h01;
    end
    // Starts full so the first power-up after reset is not flagged
    always_ff @(posedge ref_clk) begin
        if (srst) off_gap <= 8'hff;
        else if (rail_en != 5'h00) off_gap <= 8'h00;
        else if (off_gap != 8'hff) off_gap <= off_gap + 8'h01;
    end
    always_ff @(posedge ref_clk) begin
        if (srst || rail_en != 5'h1f || reset_n) hold_cnt <= 8'h00;
        else if (hold_cnt != 8'hff) hold_cnt <= hold_cnt + 8'h01;
    end
    sequence s_stream_req;
        cfg_we && cfg_addr == 16'h301a && cfg_wdata[2];
    endsequence
    sequence s_stream_on;
        !standby && !pix_oe_n;
    endsequence
    a_rail_order: assert property (
        rail_en inside {5'h00, 5'h01, 5'h03, 5'h07, 5'h0f, 5'h1f})
        else $error("rail enables out of order");
    a_clock_rails: assert property (
        external_ref_clock |-> rail_en == 5'h1f)
        else $error("clock runs without all rails");
    a_reset_hold: assert property (
        $rose(reset_n) |-> hold_cnt >= 8'h14)
        else $error("reset released too early");
    a_pix_tristate: assert property (
        !reset_n && !$past(reset_n, 4) |-> pix_oe_n)
        else $error("pixel pins driven in reset");
    a_cfg_after_init: assert property (
        cfg_we |-> init_done)
        else $error("write before init done");
    a_lock_wait: assert property (
        s_stream_req |-> we_gap >= 8'h09 && standby)
        else $error("stream write before lock");
    a_stream_start: assert property (
        s_stream_req |-> ##[1:8] s_stream_on)
        else $error("streaming did not start");
    a_row_finish: assert property (
        cfg_we && !cfg_wdata[2] && !pix_oe_n |->
        ##[0:16] line_end ##[1:8] standby)
        else $error("row not finished before standby");
    a_off_standby: assert property (
        $fell(rail_en[4]) |-> standby && !reset_n)
        else $error("rails off before standby");
    a_off_gap: assert property (
        $rose(rail_en[0]) |-> off_gap >= 8'h14)
        else $error("power-up too soon after power-down");
endmodule

// ==== testbench/tb_sensor_power_sequencer.sv ====
// Self-checking bench for the host and sensor ends of the sequencer
`timescale 1ns/100ps
module tb_sensor_power_sequencer;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic power_on = 1'b0;
    logic powered;
    logic busy;
    logic streaming;
    int n_errors = 0;
    int num_checks = 0;
    // Shortened waits keep the run small; both ends share one init count
    localparam int TB_STEP = 4;
    localparam int TB_RESET = 20;
    localparam int TB_INIT = 10;
    localparam int TB_LOCK = 10;
    localparam int TB_OFF = 20;
    localparam int TB_LINE = 8;
    sps_link_if link();
    sps_host #(.STEP_CYC(TB_STEP), .RESET_CYC(TB_RESET),
        .INIT_CLOCKS(TB_INIT), .LOCK_CYC(TB_LOCK), .OFF_CYC(TB_OFF))
        i_sps_host (.ref_clk(ref_clk),
        .srst(srst), .link(link), .power_on(power_on),
        .powered(powered), .busy(busy));
    sps_sensor #(.INIT_CLOCKS(TB_INIT), .LINE_LEN(TB_LINE)) i_sps_sensor (
        .ref_clk(ref_clk), .srst(srst), .link(link),
        .streaming(streaming));
    sps_assertions i_sps_assertions (.ref_clk(ref_clk), .srst(srst),
        .rail_en(link.rail_en), .external_ref_clock(link.external_ref_clock),
        .reset_n(link.reset_n), .cfg_we(link.cfg_we),
        .cfg_addr(link.cfg_addr), .cfg_wdata(link.cfg_wdata),
        .standby(link.standby), .init_done(link.init_done),
        .pix_oe_n(link.pix_oe_n), .line_end(link.line_end));
    always #10 ref_clk = ~ref_clk;
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // One power transition; logs every new rail pattern on the way
    task automatic power(input logic on, input logic [4:0] exp [5]);
        logic [4:0] seen [$];
        logic [4:0] last;
        int n_zero;
        last = link.rail_en;
        n_zero = 0;
        power_on = on;
        for (int i = 0; i < 3000; i++) begin
            @(posedge ref_clk);
            #1;
            if (link.rail_en !== last) seen.push_back(link.rail_en);
            last = link.rail_en;
            if (link.rail_en == 5'h00) n_zero++;
            if (!link.reset_n) check("pix_oe_n", link.pix_oe_n, 1'b1);
            if (i > 2 && busy === 1'b0) break;
        end
        check("busy", busy, 1'b0);
        if (busy !== 1'b0) print_verdict();
        // Stream write lands in the sensor a few cycles after busy drops
        repeat (4) @(posedge ref_clk);
        #1;
        check("rail steps", seen.size(), 5);
        foreach (exp[k]) check("rail_en", seen[k], exp[k]);
        check("streaming", streaming, on);
        check("pix_oe_n", link.pix_oe_n, !on);
        check("reset_n", link.reset_n, on);
        check("ref clock", link.external_ref_clock === 1'b1 && !on, 0);
        if (!on) check("off wait", n_zero >= 20, 1'b1);
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        check("rail_en", link.rail_en, 5'h00);
        check("pix_oe_n", link.pix_oe_n, 1'b1);
        // Second pass proves a clean restart after the off wait
        for (int n = 0; n < 2; n++) begin
            power(1'b1, '{5'h01, 5'h03, 5'h07, 5'h0f, 5'h1f});
            power(1'b0, '{5'h0f, 5'h07, 5'h03, 5'h01, 5'h00});
        end
        print_verdict();
    end
endmodule
